// *** rtl/ifmon_params.svh ***
`ifndef IFMON_PARAMS_SVH
`define IFMON_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte addresses (one aligned 32-bit word each)
// ----------------------------------------------------------------------
`define IFMON_OFS_SUPPLY 8'h00
`define IFMON_OFS_EDGE 8'h04
`define IFMON_OFS_PRI0 8'h08
`define IFMON_OFS_PRI1 8'h0C
`define IFMON_OFS_PRI2 8'h10
`define IFMON_OFS_PRI3 8'h14
`define IFMON_OFS_GRP0 8'h18
`define IFMON_GRP_STRIDE 8'h04

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define IFMON_SUP_RESULT_BIT 5
`define IFMON_SUP_ENABLE_BIT 4
`define IFMON_RESET_BYTE 8'h00
`define IFMON_LOW_GROUP 3
`define IFMON_GROUPS 10
`define IFMON_PINS 4

// Implemented sub-source slots per group, slot 3 is the top nibble bit
`define IFMON_GRP_MASK 40'h77_773F_F3FF

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define IFMON_CLK_PERIOD_NS 20
`define IFMON_REQ_DELAY_US 15
`define IFMON_REQ_DELAY_CYC \
    ((`IFMON_REQ_DELAY_US * 1000 + `IFMON_CLK_PERIOD_NS - 1) / `IFMON_CLK_PERIOD_NS)

`endif

// *** rtl/ifmon_pkg.sv ***
package ifmon_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DLY_IDLE = 2'b00,
        DLY_COUNT = 2'b01,
        DLY_FIRED = 2'b10
    } ifmon_dly_e;

    // Supply monitor control fields held by software
    typedef struct packed {
        logic enable;
        logic [2:0] thresh;
    } ifmon_mon_s;

endpackage

// *** rtl/ifmon_top.sv ***
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "ifmon_params.svh"
// Functional notes
// - Three-bit threshold code, eight detection levels.
// - Result bit 5 high while supply low.
// - Enable bit 4 switches monitor on/off.
// - Sleep mode forces monitor off.
// - Result may toggle freely, no filtering; here a level counts only once stages two and three agree.
// - Request flag sets after fixed delay.
// - Low-supply request routed through a group.
// - Flag setting wakes device from idle.
// - Per-pin edge code: off/rise/fall/both.
// - Edge fields packed pin3 high to pin0 low.
// - Four external pins raise requests.
// - Hardware sets flags, software writes enables.
// - Flag 1 pending, enable 1 enabled.
// - Primary byte 0 layout with global enable.
// - Four primary and ten group registers.
// - Unimplemented bits read zero.
// - Accepted request suspends main program.
// - Low-supply flag bit 4, enable bit 0.
module ifmon_top #(
    parameter int unsigned REQ_DELAY_CYC = `IFMON_REQ_DELAY_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // External pins and comparator result, asynchronous
    input wire logic [3:0] external_int_pin,
    input wire logic low_supply_raw,
    // Power mode from the core, same clock
    input wire logic sleep_mode,
    input wire logic idle_mode,
    // Peripheral event pulses, same clock
    input wire logic adc_event,
    input wire logic [39:0] group_event,
    // Outputs to the core and the analog comparator
    output logic cpu_int_req,
    output logic idle_wake,
    output logic monitor_on,
    output logic [2:0] threshold_select
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    localparam logic [39:0] GRP_MASK = `IFMON_GRP_MASK;
    localparam logic [15:0] DLY_LAST = 16'(REQ_DELAY_CYC - 1);

    ifmon_pkg::ifmon_mon_s mon_ctrl_r;
    ifmon_pkg::ifmon_dly_e dly_state_r;
    logic [15:0] dly_cnt_r;
    logic [7:0] edge_sel_r;
    logic glob_en_r;
    logic [3:0] pin_flag_r;
    logic [3:0] pin_en_r;
    logic [9:0] grp_flag_r;
    logic [9:0] grp_en_r;
    logic adc_flag_r;
    logic adc_en_r;
    logic [39:0] sub_flag_r;
    logic [39:0] sub_en_r;
    logic wait_r;
    logic [31:0] rdata_r;
    logic [7:0] rd_byte;
    logic wr_go;
    logic [7:0] wd;
    logic [3:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_stable_r, pin_prev_r;
    logic [3:0] pin_evt;
    logic sup_s1_r, sup_s2_r, sup_s3_r, sup_stable_r;
    logic mon_on_r;
    logic result_r;
    logic low_evt;
    logic [39:0] sub_evt;
    logic [9:0] grp_set;
    logic int_req_r;
    logic wake_r;

    // Word-address match, shared by every write and read decode
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr[7:2] == ofs[7:2]);
    endfunction

    // ------------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, then the answer cycle
    // ------------------------------------------------------------------
    // Waitrequest drops for exactly one cycle per request
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            wait_r <= 1'b1;
        else
            wait_r <= !((avs_read || avs_write) && wait_r);
    end

    // Writes take effect at the edge where waitrequest is seen low
    assign wr_go = avs_write && !wait_r && avs_byteenable[0];
    assign wd = avs_writedata[7:0];

    // Read data captured one cycle early so it stands during the answer
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            rdata_r <= 32'h0000_0000;
        else if (avs_read && wait_r)
            rdata_r <= {24'h00_0000, rd_byte};
    end

    // Read view of every register; unmapped words and gaps read zero
    always_comb
    begin
        rd_byte = 8'h00;
        if (hit(avs_address, `IFMON_OFS_SUPPLY))
            rd_byte = {2'b00, result_r, mon_ctrl_r.enable, 1'b0, mon_ctrl_r.thresh};
        else if (hit(avs_address, `IFMON_OFS_EDGE))
            rd_byte = edge_sel_r;
        else if (hit(avs_address, `IFMON_OFS_PRI0))
            rd_byte = {1'b0, grp_flag_r[6], pin_flag_r[1], pin_flag_r[0],
                grp_en_r[6], pin_en_r[1], pin_en_r[0], glob_en_r};
        else if (hit(avs_address, `IFMON_OFS_PRI1))
            rd_byte = {adc_flag_r, grp_flag_r[1], grp_flag_r[0], grp_flag_r[7],
                adc_en_r, grp_en_r[1], grp_en_r[0], grp_en_r[7]};
        else if (hit(avs_address, `IFMON_OFS_PRI2))
            rd_byte = {grp_flag_r[3], grp_flag_r[9], grp_flag_r[8], grp_flag_r[2],
                grp_en_r[3], grp_en_r[9], grp_en_r[8], grp_en_r[2]};
        else if (hit(avs_address, `IFMON_OFS_PRI3))
            rd_byte = {grp_flag_r[5], grp_flag_r[4], pin_flag_r[3], pin_flag_r[2],
                grp_en_r[5], grp_en_r[4], pin_en_r[3], pin_en_r[2]};
        else
            for (int g = 0; g < `IFMON_GROUPS; g++)
                if (hit(avs_address, 8'(`IFMON_OFS_GRP0 + g * `IFMON_GRP_STRIDE)))
                    rd_byte = {sub_flag_r[g*4 +: 4] & GRP_MASK[g*4 +: 4],
                        sub_en_r[g*4 +: 4] & GRP_MASK[g*4 +: 4]};
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Three stages; a level counts only once stages two and three agree
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            pin_s3_r <= 4'h0;
            sup_s1_r <= 1'b0;
            sup_s2_r <= 1'b0;
            sup_s3_r <= 1'b0;
        end
        else
        begin
            pin_s1_r <= external_int_pin;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            sup_s1_r <= low_supply_raw;
            sup_s2_r <= sup_s1_r;
            sup_s3_r <= sup_s2_r;
        end
    end

    // ------------------------------------------------------------------
    // External pin edge detection
    // ------------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < `IFMON_PINS; p++)
        begin : g_pin
            // Stable level and its previous value per pin
            always_ff @(posedge clk_sys)
            begin
                if (srst)
                begin
                    pin_stable_r[p] <= 1'b0;
                    pin_prev_r[p] <= 1'b0;
                end
                else
                begin
                    if (pin_s2_r[p] == pin_s3_r[p])
                        pin_stable_r[p] <= pin_s3_r[p];
                    pin_prev_r[p] <= pin_stable_r[p];
                end
            end
            // Low select bit picks rising, high bit picks falling
            assign pin_evt[p] =
                (edge_sel_r[2*p] && pin_stable_r[p] && !pin_prev_r[p]) ||
                (edge_sel_r[2*p+1] && !pin_stable_r[p] && pin_prev_r[p]);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Supply monitor
    // ------------------------------------------------------------------
    // Control fields written by software
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            mon_ctrl_r <= '0;
            edge_sel_r <= `IFMON_RESET_BYTE;
        end
        else if (wr_go)
        begin
            if (hit(avs_address, `IFMON_OFS_SUPPLY))
            begin
                mon_ctrl_r.enable <= wd[`IFMON_SUP_ENABLE_BIT];
                mon_ctrl_r.thresh <= wd[2:0];
            end
            if (hit(avs_address, `IFMON_OFS_EDGE))
                edge_sel_r <= wd;
        end
    end

    // Sleep overrides the stored enable; comparator result counts only once stages two and three agree
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            mon_on_r <= 1'b0;
            sup_stable_r <= 1'b0;
            result_r <= 1'b0;
        end
        else
        begin
            mon_on_r <= mon_ctrl_r.enable && !sleep_mode;
            if (sup_s2_r == sup_s3_r)
                sup_stable_r <= sup_s3_r;
            result_r <= mon_on_r && sup_stable_r;
        end
    end

    assign monitor_on = mon_on_r;
    assign threshold_select = mon_ctrl_r.thresh;

    // Request delay: result must stay high for the whole count
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            dly_state_r <= ifmon_pkg::DLY_IDLE;
            dly_cnt_r <= 16'h0000;
        end
        else
        begin
            unique case (dly_state_r)
                ifmon_pkg::DLY_IDLE:
                begin
                    dly_cnt_r <= 16'h0000;
                    if (result_r)
                        dly_state_r <= ifmon_pkg::DLY_COUNT;
                end
                ifmon_pkg::DLY_COUNT:
                begin
                    if (!result_r)
                        dly_state_r <= ifmon_pkg::DLY_IDLE;
                    else if (dly_cnt_r == DLY_LAST)
                        dly_state_r <= ifmon_pkg::DLY_FIRED;
                    else
                        dly_cnt_r <= dly_cnt_r + 16'h0001;
                end
                ifmon_pkg::DLY_FIRED:
                begin
                    if (!result_r)
                        dly_state_r <= ifmon_pkg::DLY_IDLE;
                end
                default:
                    dly_state_r <= ifmon_pkg::DLY_IDLE;
            endcase
        end
    end

    assign low_evt = (dly_state_r == ifmon_pkg::DLY_COUNT) && result_r &&
        (dly_cnt_r == DLY_LAST);

    // ------------------------------------------------------------------
    // Request flags and enables
    // ------------------------------------------------------------------
    // Low-supply event takes the slot of flag bit 4 in group 3
    always_comb
    begin
        sub_evt = group_event;
        sub_evt[`IFMON_LOW_GROUP*4] = low_evt;
    end

    // A group flag rises when an enabled member raises its event
    generate
        for (p = 0; p < `IFMON_GROUPS; p++)
        begin : g_grp
            assign grp_set[p] = |(sub_evt[p*4 +: 4] & sub_en_r[p*4 +: 4] &
                GRP_MASK[p*4 +: 4]);
        end
    endgenerate

    // Group member registers; hardware set wins over a software clear
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sub_flag_r <= 40'h00_0000_0000;
            sub_en_r <= 40'h00_0000_0000;
        end
        else
        begin
            for (int g = 0; g < `IFMON_GROUPS; g++)
                if (wr_go && hit(avs_address, 8'(`IFMON_OFS_GRP0 + g * `IFMON_GRP_STRIDE)))
                begin
                    sub_flag_r[g*4 +: 4] <= (wd[7:4] | sub_evt[g*4 +: 4]) &
                        GRP_MASK[g*4 +: 4];
                    sub_en_r[g*4 +: 4] <= wd[3:0] & GRP_MASK[g*4 +: 4];
                end
                else
                    sub_flag_r[g*4 +: 4] <= (sub_flag_r[g*4 +: 4] | sub_evt[g*4 +: 4]) &
                        GRP_MASK[g*4 +: 4];
        end
    end

    // Primary registers; software writes land first, hardware sets on top
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            glob_en_r <= 1'b0;
            pin_flag_r <= 4'h0;
            pin_en_r <= 4'h0;
            grp_flag_r <= 10'h000;
            grp_en_r <= 10'h000;
            adc_flag_r <= 1'b0;
            adc_en_r <= 1'b0;
        end
        else
        begin
            logic [3:0] pf;
            logic [9:0] gf;
            logic af;
            pf = pin_flag_r;
            gf = grp_flag_r;
            af = adc_flag_r;
            if (wr_go && hit(avs_address, `IFMON_OFS_PRI0))
            begin
                {gf[6], pf[1], pf[0]} = wd[6:4];
                {grp_en_r[6], pin_en_r[1], pin_en_r[0], glob_en_r} <= wd[3:0];
            end
            if (wr_go && hit(avs_address, `IFMON_OFS_PRI1))
            begin
                {af, gf[1], gf[0], gf[7]} = wd[7:4];
                {adc_en_r, grp_en_r[1], grp_en_r[0], grp_en_r[7]} <= wd[3:0];
            end
            if (wr_go && hit(avs_address, `IFMON_OFS_PRI2))
            begin
                {gf[3], gf[9], gf[8], gf[2]} = wd[7:4];
                {grp_en_r[3], grp_en_r[9], grp_en_r[8], grp_en_r[2]} <= wd[3:0];
            end
            if (wr_go && hit(avs_address, `IFMON_OFS_PRI3))
            begin
                {gf[5], gf[4], pf[3], pf[2]} = wd[7:4];
                {grp_en_r[5], grp_en_r[4], pin_en_r[3], pin_en_r[2]} <= wd[3:0];
            end
            pin_flag_r <= pf | pin_evt;
            grp_flag_r <= gf | grp_set;
            adc_flag_r <= af | adc_event;
        end
    end

    // ------------------------------------------------------------------
    // Outputs to the core
    // ------------------------------------------------------------------
    // The core suspends its program while this request is presented
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            int_req_r <= 1'b0;
            wake_r <= 1'b0;
        end
        else
        begin
            int_req_r <= glob_en_r && |{pin_flag_r & pin_en_r, grp_flag_r & grp_en_r,
                adc_flag_r & adc_en_r};
            // Wake only when the flag newly sets; a preset flag keeps the core idle
            wake_r <= idle_mode && low_evt && !sub_flag_r[`IFMON_LOW_GROUP*4];
        end
    end

    assign cpu_int_req = int_req_r;
    assign idle_wake = wake_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [15:0] hi_cnt_r;

    // Consecutive cycles with the result high, saturating
    always_ff @(posedge clk_sys)
    begin
        if (srst || !result_r)
            hi_cnt_r <= 16'h0000;
        else if (hi_cnt_r != 16'hFFFF)
            hi_cnt_r <= hi_cnt_r + 16'h0001;
    end

    sequence s_low_set;
        low_evt && mon_ctrl_r.enable ##1 sub_flag_r[`IFMON_LOW_GROUP*4];
    endsequence

    chk_delay_count: assert property (@(posedge clk_sys) disable iff (srst)
        low_evt |-> hi_cnt_r == 16'(REQ_DELAY_CYC))
        else $error("low-supply request before delay elapsed");
    chk_sleep_off: assert property (@(posedge clk_sys) disable iff (srst)
        sleep_mode |=> !monitor_on ##1 !result_r)
        else $error("monitor active during sleep");
    chk_result_gate: assert property (@(posedge clk_sys) disable iff (srst)
        result_r |-> $past(mon_ctrl_r.enable, 2) && !$past(sleep_mode, 2) &&
            $past(sup_stable_r))
        else $error("result high without active low supply");
    chk_low_flag: assert property (@(posedge clk_sys) disable iff (srst)
        s_low_set |-> ##[0:2] (grp_flag_r[`IFMON_LOW_GROUP] || !sub_en_r[`IFMON_LOW_GROUP*4]))
        else $error("low-supply event missing from group flag");
    chk_idle_wake: assert property (@(posedge clk_sys) disable iff (srst)
        low_evt && idle_mode && !sub_flag_r[`IFMON_LOW_GROUP*4] |=> idle_wake ##1 !idle_wake)
        else $error("idle wake not pulsed on low-supply request");
    chk_int_gate: assert property (@(posedge clk_sys) disable iff (srst)
        cpu_int_req |-> $past(glob_en_r))
        else $error("request presented with global enable off");
    chk_edge_off: assert property (@(posedge clk_sys) disable iff (srst)
        edge_sel_r[1:0] == 2'b00 && !pin_flag_r[0] && !wr_go |=> !pin_flag_r[0])
        else $error("disabled pin raised a request");
    chk_read_zero: assert property (@(posedge clk_sys) disable iff (srst)
        !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("upper read data not zero");
    chk_bus_answer: assert property (@(posedge clk_sys) disable iff (srst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest not low for one cycle");
    chk_reset_clear: assert property (@(posedge clk_sys)
        srst |=> glob_en_r == 1'b0 && mon_ctrl_r == '0 && edge_sel_r == 8'h00 && sub_en_r == '0)
        else $error("register not cleared by reset");

endmodule

// *** testbench/ifmon_supply_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Supply comparator and core power-mode model
// ----------------------------------------------------------------------
module ifmon_supply_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // From the block
    input wire logic [2:0] threshold_select,
    input wire logic monitor_on,
    input wire logic idle_wake,
    // From the bench
    input wire logic [12:0] supply_mv,
    input wire logic idle_req,
    // To the block
    output logic low_supply_raw,
    output logic idle_mode
);
    logic [12:0] level;
    logic noise_r;

    // Trip level in millivolts per threshold code
    always_comb
    begin
        case (threshold_select)
            3'h0: level = 13'h0708;
            3'h1: level = 13'h07D0;
            3'h2: level = 13'h0960;
            3'h3: level = 13'h0A8C;
            3'h4: level = 13'h0BB8;
            3'h5: level = 13'h0CE4;
            3'h6: level = 13'h0E10;
            default: level = 13'h0FA0;
        endcase
    end

    // A switched-off comparator has no settled output, so it chatters
    always_ff @(posedge clk_sys)
    begin
        noise_r <= srst ? 1'b0 : !noise_r;
    end
    assign low_supply_raw = monitor_on ? (supply_mv < level) : noise_r;

    // Core enters idle on request and leaves it on a wake pulse
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            idle_mode <= 1'b0;
        else if (idle_wake)
            idle_mode <= 1'b0;
        else if (idle_req)
            idle_mode <= 1'b1;
    end
endmodule

// *** testbench/ifmon_tb_top.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Register-level bench
// ----------------------------------------------------------------------
module ifmon_tb_top;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [3:0] pins = 4'h0;
    logic low_supply_raw, idle_mode, idle_req = 1'b0, sleep_mode = 1'b0;
    logic adc_event = 1'b0;
    logic [39:0] group_event = 40'h00_0000_0000;
    logic cpu_int_req, idle_wake, monitor_on;
    logic [2:0] threshold_select;
    logic [12:0] supply_mv = 13'h1388;
    logic [7:0] q;
    int err_total = 0;
    int check_count = 0;
    int wake_cnt = 0;
    // Readback masks: unimplemented bits read as zero
    logic [7:0] rb_mask [0:16] = '{8'h17, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'h33, 8'hFF, 8'hFF, 8'h33, 8'h77, 8'h77, 8'h77, 8'h77, 8'h00};

    ifmon_top #(.REQ_DELAY_CYC(20)) u_dut (.clk_sys(clk_sys), .srst(srst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .external_int_pin(pins), .low_supply_raw(low_supply_raw), .sleep_mode(sleep_mode),
        .idle_mode(idle_mode), .adc_event(adc_event), .group_event(group_event),
        .cpu_int_req(cpu_int_req), .idle_wake(idle_wake), .monitor_on(monitor_on),
        .threshold_select(threshold_select));

    ifmon_supply_model u_model (.clk_sys(clk_sys), .srst(srst),
        .threshold_select(threshold_select), .monitor_on(monitor_on), .idle_wake(idle_wake),
        .supply_mv(supply_mv), .idle_req(idle_req), .low_supply_raw(low_supply_raw),
        .idle_mode(idle_mode));

    // 50 MHz clock
    initial
    begin
        forever #10 clk_sys = !clk_sys;
    end

    // Wake pulses are one cycle wide, so count them on every edge
    always @(posedge clk_sys)
    begin
        if (idle_wake === 1'b1)
            wake_cnt++;
    end

    task automatic test_done();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // One Avalon transfer; an idle edge first keeps drives one per time step
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h00_0000, d};
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0)
        begin
            n++;
            if (n > 50)
            begin
                err_total++;
                $display("[ERR] waitrequest expected 0 seen %b", avs_waitrequest);
                test_done();
            end
            @(posedge clk_sys);
        end
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(what, exp, q);
    endtask

    // Main sequence
    initial
    begin
        cyc(3);
        srst <= 1'b0;
        for (int i = 0; i < 17; i++)
            rd_chk("reset value", 8'(i * 4), 8'h00);
        for (int i = 0; i < 17; i++)
            bus(1'b1, 8'(i * 4), 8'hFF);
        for (int i = 0; i < 17; i++)
            rd_chk("readback", 8'(i * 4), rb_mask[i]);
        chk("request out", 8'h01, {7'h00, cpu_int_req});
        chk("threshold", 8'h07, {5'h00, threshold_select});
        chk("monitor on", 8'h01, {7'h00, monitor_on});
        sleep_mode <= 1'b1;
        cyc(3);
        chk("monitor asleep", 8'h00, {7'h00, monitor_on});
        sleep_mode <= 1'b0;
        for (int i = 0; i < 16; i++)
            bus(1'b1, 8'(i * 4), 8'h00);
        chk("request out", 8'h00, {7'h00, cpu_int_req});
        avs_byteenable <= 4'h0;
        bus(1'b1, 8'h04, 8'hAA);
        avs_byteenable <= 4'h1;
        rd_chk("lane off write", 8'h04, 8'h00);
        // Every edge code on every pin, flag polled after each edge
        for (int p = 0; p < 4; p++)
            for (int c = 0; c < 4; c++)
            begin
                bus(1'b1, 8'h04, 8'(c << (2 * p)));
                pins[p] <= 1'b1;
                cyc(10);
                bus(1'b0, (p < 2) ? 8'h08 : 8'h14, 8'h00);
                chk("rise flag", {7'h00, c[0]}, {7'h00, q[4 + p % 2]});
                bus(1'b1, (p < 2) ? 8'h08 : 8'h14, 8'h00);
                pins[p] <= 1'b0;
                cyc(10);
                bus(1'b0, (p < 2) ? 8'h08 : 8'h14, 8'h00);
                chk("fall flag", {7'h00, c[1]}, {7'h00, q[4 + p % 2]});
                bus(1'b1, (p < 2) ? 8'h08 : 8'h14, 8'h00);
            end
        bus(1'b1, 8'h04, 8'h01);
        bus(1'b1, 8'h08, 8'h03);
        pins[0] <= 1'b1;
        cyc(10);
        chk("request out", 8'h01, {7'h00, cpu_int_req});
        bus(1'b1, 8'h08, 8'h12);
        cyc(3);
        chk("request global off", 8'h00, {7'h00, cpu_int_req});
        adc_event <= 1'b1;
        group_event[0] <= 1'b1;
        cyc(1);
        adc_event <= 1'b0;
        group_event[0] <= 1'b0;
        rd_chk("converter flag", 8'h0C, 8'h80);
        rd_chk("member flag", 8'h18, 8'h10);
        // Low supply: result, delayed request, group route and idle wake
        bus(1'b1, 8'h24, 8'h01);
        bus(1'b1, 8'h10, 8'h08);
        bus(1'b1, 8'h08, 8'h01);
        bus(1'b1, 8'h00, 8'h13);
        cyc(10);
        supply_mv <= 13'h09C4;
        idle_req <= 1'b1;
        cyc(1);
        idle_req <= 1'b0;
        cyc(5);
        rd_chk("low result", 8'h00, 8'h33);
        rd_chk("early flag", 8'h24, 8'h01);
        cyc(30);
        rd_chk("low flag", 8'h24, 8'h11);
        rd_chk("group flag", 8'h10, 8'h88);
        chk("request out", 8'h01, {7'h00, cpu_int_req});
        chk("woken", 8'h00, {7'h00, idle_mode});
        // Preset flag keeps the core idle
        supply_mv <= 13'h1388;
        cyc(10);
        bus(1'b1, 8'h24, 8'h11);
        idle_req <= 1'b1;
        cyc(1);
        idle_req <= 1'b0;
        supply_mv <= 13'h09C4;
        cyc(40);
        chk("still idle", 8'h01, {7'h00, idle_mode});
        chk("wake count", 8'h01, 8'(wake_cnt));
        sleep_mode <= 1'b1;
        cyc(8);
        rd_chk("asleep result", 8'h00, 8'h13);
        test_done();
    end
endmodule
